// *** nims_pkg.sv ***
// constants and state layout of the nfc interrupt mask and status block
package nims_pkg;

	localparam int          NIMS_GROUPS       = 4;
	localparam logic [7:0]  ADDR_MASK_MAIN    = 8'h16;
	localparam logic [7:0]  ADDR_MASK_TIMER   = 8'h17;
	localparam logic [7:0]  ADDR_MASK_ERROR   = 8'h18;
	localparam logic [7:0]  ADDR_MASK_TARGET  = 8'h19;
	localparam logic [7:0]  ADDR_STAT_MAIN    = 8'h1A;
	localparam logic [7:0]  ADDR_STAT_TIMER   = 8'h1B;
	localparam logic [7:0]  ADDR_STAT_ERROR   = 8'h1C;
	localparam logic [7:0]  ADDR_STAT_TARGET  = 8'h1D;

	// implemented bits per group: main, timer/field, error/wake-up, target
	localparam logic [7:0]  BITS_MAIN         = 8'hFE;
	localparam logic [7:0]  BITS_TIMER        = 8'hFF;
	localparam logic [7:0]  BITS_ERROR        = 8'hFF;
	localparam logic [7:0]  BITS_TARGET       = 8'hFB;
	localparam logic [7:0]  MASK_RESET        = 8'h00;

	// main group bit positions
	localparam int          BIT_OSC           = 7;
	localparam int          BIT_FIFO_LEVEL    = 6;
	localparam int          BIT_RX_START      = 5;
	localparam int          BIT_RX_END        = 4;
	localparam int          BIT_TX_END        = 3;
	localparam int          BIT_COLLISION     = 2;
	localparam int          BIT_RX_RESTART    = 1;

	localparam int          FIFO_CNT_W        = 10;
	localparam logic [9:0]  FIFO_RX_LEVEL     = 10'h12C;
	localparam logic [9:0]  FIFO_TX_LEVEL     = 10'h0C8;

	typedef struct packed {
		logic [NIMS_GROUPS-1:0][7:0] mask;
		logic [NIMS_GROUPS-1:0][7:0] stat;
		logic                        osc_prev;
		logic                        rx_lvl_prev;
		logic                        tx_lvl_prev;
		logic [7:0]                  rdata;
		logic                        irq;
	} nims_state_s;

endpackage

// *** nims_irq_ctrl.sv ***
// interrupt mask and read-to-clear status registers with interrupt output
`timescale 1ns/1ns

//////////////////////////////////////////////////////////////////////////////////////////
// Contract
// - main mask bits 7..1 block oscillator, fifo, rx, tx, collision, restart; bit 0 unused.
// - timer and field mask bits 7..0 block command, timeouts, field events, guard and bit rate.
// - error and wake-up mask bits 7..0 block crc, parity, framing and the four wake-up causes.
// - target mask bits 7..0 block target events from field-wait timer down, bit 2 reserved.
// - a mask bit at 1 blocks its source, at 0 enables it, and all mask bits reset to 0.
// - main status is read-only with flags in bits 7..1 and bit 0 reserved.
// - the oscillator-stable flag is set when the enabled oscillator becomes stable.
// - while receiving the fifo level flag is set when the fifo holds more than 300 bytes.
// - while transmitting the fifo level flag is set when the fifo holds fewer than 200 bytes.
// - rx restart flag bit 1 is set when a frame is discarded as disturbance and rx restarts.
// - reading a status register clears all its flags to 0, except a flag whose event arrives in the same cycle, which stays set.
// - timer and field status bits 7..0 record timer_field_evt bit for bit, independent of the timer and field mask.
module nims_irq_ctrl
	import nims_pkg::*;
(
	input  wire logic                  clk_sys,
	input  wire logic                  rst,
	input  wire logic [7:0]            reg_addr,
	input  wire logic                  reg_wr,
	input  wire logic [7:0]            reg_wdata,
	input  wire logic                  reg_rd,
	output logic      [7:0]            reg_rdata,
	input  wire logic                  osc_stable,
	input  wire logic                  rx_active,
	input  wire logic                  tx_active,
	input  wire logic [FIFO_CNT_W-1:0] fifo_count,
	input  wire logic                  rx_start,
	input  wire logic                  rx_end,
	input  wire logic                  tx_end,
	input  wire logic                  bit_collision,
	input  wire logic                  em_disturbance,
	input  wire logic [7:0]            timer_field_evt,
	input  wire logic [7:0]            error_wakeup_evt,
	input  wire logic [7:0]            target_evt,
	output logic                       irq
);

	localparam logic [NIMS_GROUPS-1:0][7:0] GROUP_BITS =
		{BITS_TARGET, BITS_ERROR, BITS_TIMER, BITS_MAIN};

	nims_state_s                 st;
	nims_state_s                 next_st;
	logic [NIMS_GROUPS-1:0][7:0] ev;
	logic                        rx_lvl;
	logic                        tx_lvl;

	//////////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_st = st;
		rx_lvl = rx_active && (fifo_count > FIFO_RX_LEVEL);
		tx_lvl = tx_active && (fifo_count < FIFO_TX_LEVEL);
		ev = '0;
		ev[0][BIT_OSC] = osc_stable && !st.osc_prev;
		ev[0][BIT_FIFO_LEVEL] = (rx_lvl && !st.rx_lvl_prev) || (tx_lvl && !st.tx_lvl_prev);
		ev[0][BIT_RX_START] = rx_start;
		ev[0][BIT_RX_END] = rx_end;
		ev[0][BIT_TX_END] = tx_end;
		ev[0][BIT_COLLISION] = bit_collision;
		ev[0][BIT_RX_RESTART] = em_disturbance;
		ev[1] = timer_field_evt;
		ev[2] = error_wakeup_evt;
		ev[3] = target_evt;
		next_st.osc_prev = osc_stable;
		next_st.rx_lvl_prev = rx_lvl;
		next_st.tx_lvl_prev = tx_lvl;
		next_st.rdata = 8'h00;
		for (int i = 0; i < NIMS_GROUPS; i++) begin
			// reserved bits never stored
			if (reg_wr && reg_addr == ADDR_MASK_MAIN + 8'(i)) begin
				next_st.mask[i] = reg_wdata & GROUP_BITS[i];
			end
			if (reg_rd && reg_addr == ADDR_MASK_MAIN + 8'(i)) begin
				next_st.rdata = st.mask[i];
			end
			if (reg_rd && reg_addr == ADDR_STAT_MAIN + 8'(i)) begin
				next_st.rdata = st.stat[i];
			end
			// a new event wins over the read clear
			if (reg_rd && reg_addr == ADDR_STAT_MAIN + 8'(i)) begin
				next_st.stat[i] = ev[i] & GROUP_BITS[i];
			end else begin
				next_st.stat[i] = (st.stat[i] | ev[i]) & GROUP_BITS[i];
			end
		end
		next_st.irq = 1'b0;
		for (int i = 0; i < NIMS_GROUPS; i++) begin
			next_st.irq = next_st.irq | (|(next_st.stat[i] & ~next_st.mask[i]));
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign reg_rdata = st.rdata;
	assign irq = st.irq;

	//////////////////////////////////////////////////////////////////////////////////////
	reset_mask_a: assert property (@(posedge clk_sys)
		$past(rst) |-> (st.mask == '0 && !irq))
		else $error("masks not cleared by reset");

	irq_relation_a: assert property (@(posedge clk_sys) disable iff (rst)
		irq == (|(st.stat & ~st.mask)))
		else $error("irq does not follow unmasked flags");

	read_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
		(reg_rd && reg_addr == ADDR_STAT_ERROR && error_wakeup_evt == 8'h00)
		|=> (st.stat[2] == 8'h00 && reg_rdata == $past(st.stat[2])))
		else $error("error status not cleared or returned on read");

	osc_flag_a: assert property (@(posedge clk_sys) disable iff (rst)
		$rose(osc_stable) |=> st.stat[0][BIT_OSC])
		else $error("oscillator flag not set");

	fifo_rx_a: assert property (@(posedge clk_sys) disable iff (rst)
		(rx_active && fifo_count > FIFO_RX_LEVEL && !st.rx_lvl_prev)
		|=> st.stat[0][BIT_FIFO_LEVEL])
		else $error("fifo level flag missed in receive");

	fifo_tx_a: assert property (@(posedge clk_sys) disable iff (rst)
		(tx_active && fifo_count < FIFO_TX_LEVEL && !st.tx_lvl_prev)
		|=> st.stat[0][BIT_FIFO_LEVEL])
		else $error("fifo level flag missed in transmit");

	restart_flag_a: assert property (@(posedge clk_sys) disable iff (rst)
		em_disturbance |=> st.stat[0][BIT_RX_RESTART])
		else $error("restart flag not set");

	main_readonly_a: assert property (@(posedge clk_sys) disable iff (rst)
		(reg_wr && reg_addr == ADDR_STAT_MAIN && !reg_rd)
		|=> (st.stat[0] & $past(st.stat[0])) == $past(st.stat[0])
			&& (st.stat[0] & ~BITS_MAIN) == 8'h00)
		else $error("main status changed by write");

	timer_flag_a: assert property (@(posedge clk_sys) disable iff (rst)
		(timer_field_evt != 8'h00)
		|=> ((st.stat[1] & $past(timer_field_evt)) == $past(timer_field_evt)))
		else $error("timer status missed event");

	mask_store_a: assert property (@(posedge clk_sys) disable iff (rst)
		(reg_wr && reg_addr == ADDR_MASK_TARGET)
		|=> st.mask[3] == ($past(reg_wdata) & BITS_TARGET))
		else $error("target mask not stored");

	mask_block_a: assert property (@(posedge clk_sys) disable iff (rst)
		(st.mask == GROUP_BITS) |-> !irq)
		else $error("masked source raised irq");

	mask_main_a: assert property (@(posedge clk_sys) disable iff (rst)
		(reg_wr && reg_addr == ADDR_MASK_MAIN)
		|=> st.mask[0] == ($past(reg_wdata) & BITS_MAIN))
		else $error("main mask not stored");

	mask_timer_a: assert property (@(posedge clk_sys) disable iff (rst)
		(reg_wr && reg_addr == ADDR_MASK_TIMER)
		|=> st.mask[1] == ($past(reg_wdata) & BITS_TIMER))
		else $error("timer mask not stored");

	mask_error_a: assert property (@(posedge clk_sys) disable iff (rst)
		(reg_wr && reg_addr == ADDR_MASK_ERROR)
		|=> st.mask[2] == ($past(reg_wdata) & BITS_ERROR))
		else $error("error mask not stored");

	mask_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
		!(reg_wr && reg_addr >= ADDR_MASK_MAIN && reg_addr <= ADDR_MASK_TARGET)
		|=> st.mask == $past(st.mask))
		else $error("mask changed without a mask write");

	rsvd_mask_a: assert property (@(posedge clk_sys) disable iff (rst)
		(st.mask[0] & ~BITS_MAIN) == 8'h00
		&& (st.mask[3] & ~BITS_TARGET) == 8'h00)
		else $error("reserved mask bit stored");

	rsvd_stat_a: assert property (@(posedge clk_sys) disable iff (rst)
		(st.stat[0] & ~BITS_MAIN) == 8'h00
		&& (st.stat[3] & ~BITS_TARGET) == 8'h00)
		else $error("reserved status bit set");

	main_read_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
		(reg_rd && reg_addr == ADDR_STAT_MAIN)
		|=> (st.stat[0] == ($past(ev[0]) & BITS_MAIN) && reg_rdata == $past(st.stat[0])))
		else $error("main status not cleared or returned on read");

	timer_read_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
		(reg_rd && reg_addr == ADDR_STAT_TIMER)
		|=> (st.stat[1] == ($past(timer_field_evt) & BITS_TIMER) && reg_rdata == $past(st.stat[1])))
		else $error("timer status not cleared or returned on read");

	target_read_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
		(reg_rd && reg_addr == ADDR_STAT_TARGET)
		|=> (st.stat[3] == ($past(target_evt) & BITS_TARGET) && reg_rdata == $past(st.stat[3])))
		else $error("target status not cleared or returned on read");

	set_wins_a: assert property (@(posedge clk_sys) disable iff (rst)
		(reg_rd && reg_addr == ADDR_STAT_MAIN && em_disturbance)
		|=> st.stat[0][BIT_RX_RESTART])
		else $error("restart flag lost to read clear");

	stat_keep_main_a: assert property (@(posedge clk_sys) disable iff (rst)
		!(reg_rd && reg_addr == ADDR_STAT_MAIN)
		|=> (st.stat[0] & $past(st.stat[0])) == $past(st.stat[0]))
		else $error("main flag dropped without a read");

	stat_keep_timer_a: assert property (@(posedge clk_sys) disable iff (rst)
		!(reg_rd && reg_addr == ADDR_STAT_TIMER)
		|=> (st.stat[1] & $past(st.stat[1])) == $past(st.stat[1]))
		else $error("timer flag dropped without a read");

	stat_keep_error_a: assert property (@(posedge clk_sys) disable iff (rst)
		!(reg_rd && reg_addr == ADDR_STAT_ERROR)
		|=> (st.stat[2] & $past(st.stat[2])) == $past(st.stat[2]))
		else $error("error flag dropped without a read");

	stat_keep_target_a: assert property (@(posedge clk_sys) disable iff (rst)
		!(reg_rd && reg_addr == ADDR_STAT_TARGET)
		|=> (st.stat[3] & $past(st.stat[3])) == $past(st.stat[3]))
		else $error("target flag dropped without a read");

	rx_start_flag_a: assert property (@(posedge clk_sys) disable iff (rst)
		rx_start
		|=> st.stat[0][BIT_RX_START])
		else $error("rx start flag not set");

	rx_end_flag_a: assert property (@(posedge clk_sys) disable iff (rst)
		rx_end
		|=> st.stat[0][BIT_RX_END])
		else $error("rx end flag not set");

	tx_end_flag_a: assert property (@(posedge clk_sys) disable iff (rst)
		tx_end
		|=> st.stat[0][BIT_TX_END])
		else $error("tx end flag not set");

	collision_flag_a: assert property (@(posedge clk_sys) disable iff (rst)
		bit_collision
		|=> st.stat[0][BIT_COLLISION])
		else $error("collision flag not set");

	error_flag_a: assert property (@(posedge clk_sys) disable iff (rst)
		(error_wakeup_evt != 8'h00)
		|=> ((st.stat[2] & $past(error_wakeup_evt)) == $past(error_wakeup_evt)))
		else $error("error status missed event");

	target_flag_a: assert property (@(posedge clk_sys) disable iff (rst)
		(target_evt != 8'h00)
		|=> ((st.stat[3] & $past(target_evt) & BITS_TARGET) == ($past(target_evt) & BITS_TARGET)))
		else $error("target status missed event");

	rdata_idle_a: assert property (@(posedge clk_sys) disable iff (rst)
		!reg_rd
		|=> reg_rdata == 8'h00)
		else $error("read data not idle");

	mask_read_main_a: assert property (@(posedge clk_sys) disable iff (rst)
		(reg_rd && reg_addr == ADDR_MASK_MAIN)
		|=> reg_rdata == $past(st.mask[0]))
		else $error("main mask read wrong");

	mask_read_target_a: assert property (@(posedge clk_sys) disable iff (rst)
		(reg_rd && reg_addr == ADDR_MASK_TARGET)
		|=> reg_rdata == $past(st.mask[3]))
		else $error("target mask read wrong");

	unmapped_read_a: assert property (@(posedge clk_sys) disable iff (rst)
		(reg_rd && (reg_addr < ADDR_MASK_MAIN || reg_addr > ADDR_STAT_TARGET))
		|=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");

	fifo_idle_a: assert property (@(posedge clk_sys) disable iff (rst)
		(!rx_active && !tx_active)
		|-> !ev[0][BIT_FIFO_LEVEL])
		else $error("fifo level event while idle");

	fifo_rx_quiet_a: assert property (@(posedge clk_sys) disable iff (rst)
		(rx_active && !tx_active && fifo_count <= FIFO_RX_LEVEL)
		|-> !ev[0][BIT_FIFO_LEVEL])
		else $error("fifo level event below receive level");

	fifo_tx_quiet_a: assert property (@(posedge clk_sys) disable iff (rst)
		(tx_active && !rx_active && fifo_count >= FIFO_TX_LEVEL)
		|-> !ev[0][BIT_FIFO_LEVEL])
		else $error("fifo level event above transmit level");

	osc_level_a: assert property (@(posedge clk_sys) disable iff (rst)
		(!osc_stable || st.osc_prev)
		|-> !ev[0][BIT_OSC])
		else $error("oscillator event without a rising edge");

	irq_unmask_a: assert property (@(posedge clk_sys) disable iff (rst)
		(st.mask == '0 && st.stat != '0)
		|-> irq)
		else $error("unmasked flag did not raise irq");

	reset_stat_a: assert property (@(posedge clk_sys)
		$past(rst)
		|-> (st.stat == '0 && reg_rdata == 8'h00))
		else $error("status or read data not cleared by reset");

endmodule

// *** nims_host_model.sv ***
// host side model issuing register writes and reads
`timescale 1ns/1ns
module nims_host_model (
	input  wire logic       clk_sys,
	input  wire logic [7:0] reg_rdata,
	output logic      [7:0] reg_addr,
	output logic            reg_wr,
	output logic      [7:0] reg_wdata,
	output logic            reg_rd
);
	initial begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_wdata = 8'h00;
		reg_rd = 1'b0;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge clk_sys);
		#1 reg_wr = 1'b0;
		// released data lines must not keep the last value
		reg_wdata = ~d;
		// idle edge so a following call never re-raises a strobe in the same step
		@(posedge clk_sys);
		#1;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge clk_sys);
		#1 reg_rd = 1'b0;
		d = reg_rdata;
		@(posedge clk_sys);
		#1;
	endtask
endmodule

// *** testbench.sv ***
// self-checking testbench of the interrupt mask and status block
`timescale 1ns/1ns
module testbench;
	import nims_pkg::*;
	localparam logic [3:0][7:0] IMPL = {BITS_TARGET, BITS_ERROR, BITS_TIMER, BITS_MAIN};
	logic            clk_sys = 1'b0;
	logic            rst = 1'b1;
	logic [7:0]      reg_addr, reg_wdata, reg_rdata, got;
	logic            reg_wr, reg_rd, irq;
	logic            osc_stable = 1'b0;
	logic            rx_active = 1'b0;
	logic            tx_active = 1'b0;
	logic [9:0]      fifo_count = 10'h000;
	logic [4:0]      pev = 5'h00;
	logic [2:0][7:0] gev = '0;
	int              bad_count = 0;
	int              check_count = 0;
	always #50 clk_sys = ~clk_sys;
	nims_host_model i_nims_host_model (.clk_sys, .reg_rdata, .reg_addr, .reg_wr, .reg_wdata, .reg_rd);
	nims_irq_ctrl i_nims_irq_ctrl (.clk_sys, .rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
		.reg_rdata, .osc_stable, .rx_active, .tx_active, .fifo_count, .rx_start(pev[4]),
		.rx_end(pev[3]), .tx_end(pev[2]), .bit_collision(pev[1]), .em_disturbance(pev[0]),
		.timer_field_evt(gev[0]), .error_wakeup_evt(gev[1]), .target_evt(gev[2]), .irq);
	task automatic tick;
		@(posedge clk_sys);
		#1;
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		check_count++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		i_nims_host_model.rd(a, got);
		chk(got, e);
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		#2000000;
		bad_count++;
		give_verdict;
	end
	//////////////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (10) @(posedge clk_sys);
		#1 rst = 1'b0;
		tick;
		for (int i = 0; i < 8; i++)
			rdc(8'h16 + 8'(i), 8'h00);
		$display("test reset values done");
		for (int i = 0; i < 4; i++) begin
			i_nims_host_model.wr(8'h16 + 8'(i), 8'hFF);
			rdc(8'h16 + 8'(i), IMPL[i]);
		end
		i_nims_host_model.wr(8'h1A, 8'hFF);
		rdc(8'h1A, 8'h00);
		i_nims_host_model.wr(8'h15, 8'hFF);
		rdc(8'h15, 8'h00);
		rdc(8'h1E, 8'h00);
		$display("test mask access done");
		pev = 5'h04;
		tick;
		pev = 5'h00;
		chk({7'h00, irq}, 8'h00);
		rdc(8'h1A, 8'h08);
		i_nims_host_model.wr(8'h16, 8'h00);
		for (int i = 0; i < 5; i++) begin
			pev = 5'(1 << i);
			tick;
			pev = 5'h00;
			chk({7'h00, irq}, 8'h01);
			rdc(8'h1A, {2'b00, 5'(1 << i), 1'b0});
			chk({7'h00, irq}, 8'h00);
		end
		pev = 5'h01;
		fork
			begin
				tick;
				pev = 5'h00;
			end
			rdc(8'h1A, 8'h00);
		join
		chk({7'h00, irq}, 8'h01);
		rdc(8'h1A, 8'h02);
		$display("test main events done");
		for (int g = 0; g < 3; g++) begin
			gev[g] = 8'hA1;
			tick;
			gev[g] = 8'h00;
			chk({7'h00, irq}, 8'h00);
			rdc(8'h1B + 8'(g), 8'hA1);
			i_nims_host_model.wr(8'h17 + 8'(g), 8'hFE);
			gev[g] = 8'h01;
			tick;
			gev[g] = 8'h00;
			chk({7'h00, irq}, 8'h01);
			rdc(8'h1B + 8'(g), 8'h01);
		end
		$display("test group events done");
		rx_active = 1'b1;
		fifo_count = 10'h12C;
		tick;
		rdc(8'h1A, 8'h00);
		fifo_count = 10'h12D;
		tick;
		rdc(8'h1A, 8'h40);
		rx_active = 1'b0;
		tx_active = 1'b1;
		fifo_count = 10'h0C8;
		tick;
		rdc(8'h1A, 8'h00);
		fifo_count = 10'h0C7;
		tick;
		rdc(8'h1A, 8'h40);
		osc_stable = 1'b1;
		tick;
		rdc(8'h1A, 8'h80);
		$display("test level events done");
		osc_stable = 1'b0;
		tx_active = 1'b0;
		gev[1] = 8'h01;
		tick;
		gev[1] = 8'h00;
		chk({7'h00, irq}, 8'h01);
		rst = 1'b1;
		repeat (2) tick;
		rst = 1'b0;
		tick;
		chk({7'h00, irq}, 8'h00);
		for (int i = 0; i < 4; i++)
			rdc(8'h16 + 8'(i), 8'h00);
		gev[2] = 8'h01;
		tick;
		gev[2] = 8'h00;
		chk({7'h00, irq}, 8'h01);
		rdc(8'h1D, 8'h01);
		$display("test mid-run reset done");
		give_verdict;
	end
endmodule
